//--- hw/rcr_calendar.sv
// Calendar register block: trim register, seven calendar registers with a
// write-unlock step, and a once-per-second advance with full carry.
// Assumes a single-master byte register port whose inputs are synchronous to i_mclk.
//
// Function
// - Seven-bit trim register, resets to 40 hex
// - Seven calendar registers, writable to set time
// - Seconds, minutes 0..59; hours 0..23
// - Year 0..99; divisible by four is leap
// - Reset leaves calendar contents untouched
// - Calendar retained across modes while powered
`timescale 1ns/1ps

module rcr_calendar #(
    parameter int unsigned SEC_CYCLES = rcr_pkg::SEC_CYCLES
) (
    input  wire logic                  i_mclk,
    input  wire logic                  i_rst_n,
    input  wire rcr_pkg::rcr_bus_req_t i_req,
    output logic [7:0]                 o_rdata,
    output logic [6:0]                 o_analog_rate_trim,
    output rcr_pkg::rcr_cal_t          o_calendar,
    output logic                       o_second_tick
);

    localparam int unsigned CW = $clog2(SEC_CYCLES);

    typedef struct packed {
        rcr_pkg::rcr_cal_t cal;
        logic [6:0]        trim;
        logic              unlock;
        logic [CW-1:0]     prescale;
        logic              tick;
        logic [7:0]        rdata;
    } rcr_state_t;

    rcr_state_t r;
    rcr_state_t next_r;

    function automatic logic is_leap(input logic [7:0] year);
        return year[1:0] == 2'h0;
    endfunction

    function automatic logic [4:0] month_length(input logic [3:0] month, input logic [7:0] year);
        logic [4:0] len;
        case (month)
            4'h4, 4'h6, 4'h9, 4'hb: len = 5'h1e;
            rcr_pkg::MONTH_FEB:     len = is_leap(year) ? 5'h1d : 5'h1c;
            default:                len = 5'h1f;
        endcase
        return len;
    endfunction

    // Out-of-range values left by firmware wrap on the next carry rather than stick
    function automatic rcr_pkg::rcr_cal_t advance(input rcr_pkg::rcr_cal_t c);
        rcr_pkg::rcr_cal_t n;
        n = c;
        if (c.seconds_count < rcr_pkg::SEC_MAX) begin
            n.seconds_count = c.seconds_count + 6'h01;
        end else begin
            n.seconds_count = '0;
            if (c.minutes_count < rcr_pkg::MIN_MAX) begin
                n.minutes_count = c.minutes_count + 6'h01;
            end else begin
                n.minutes_count = '0;
                if (c.hours_count < rcr_pkg::HOUR_MAX) begin
                    n.hours_count = c.hours_count + 5'h01;
                end else begin
                    n.hours_count = '0;
                    if (c.weekday_count >= rcr_pkg::WDAY_LAST || c.weekday_count == 3'h0) begin
                        n.weekday_count = rcr_pkg::WDAY_FIRST;
                    end else begin
                        n.weekday_count = c.weekday_count + 3'h1;
                    end
                    if (c.month_day_count < month_length(c.month_count, c.year_count)) begin
                        n.month_day_count = c.month_day_count + 5'h01;
                    end else begin
                        n.month_day_count = rcr_pkg::MDAY_FIRST;
                        if (c.month_count < rcr_pkg::MONTH_LAST) begin
                            n.month_count = c.month_count + 4'h1;
                        end else begin
                            n.month_count = rcr_pkg::MONTH_FIRST;
                            if (c.year_count < rcr_pkg::YEAR_MAX) begin
                                n.year_count = c.year_count + 8'h01;
                            end else begin
                                n.year_count = '0;
                            end
                        end
                    end
                end
            end
        end
        return n;
    endfunction

    function automatic logic [7:0] read_mux(input rcr_state_t s, input logic [15:0] addr);
        logic [7:0] d;
        d = '0;
        case (addr)
            rcr_pkg::ADDR_TRIM:   d = {1'b0, s.trim};
            rcr_pkg::ADDR_SEC:    d = {2'h0, s.cal.seconds_count};
            rcr_pkg::ADDR_MIN:    d = {2'h0, s.cal.minutes_count};
            rcr_pkg::ADDR_HOUR:   d = {3'h0, s.cal.hours_count};
            rcr_pkg::ADDR_WDAY:   d = {5'h00, s.cal.weekday_count};
            rcr_pkg::ADDR_MDAY:   d = {3'h0, s.cal.month_day_count};
            rcr_pkg::ADDR_MONTH:  d = {4'h0, s.cal.month_count};
            rcr_pkg::ADDR_YEAR:   d = s.cal.year_count;
            rcr_pkg::ADDR_UNLOCK: d = {7'h00, s.unlock};
            default:              d = '0;
        endcase
        return d;
    endfunction

    always_comb begin
        next_r       = r;
        next_r.tick  = 1'b0;
        next_r.rdata = '0;

        if (r.prescale == CW'(SEC_CYCLES - 1)) begin
            next_r.prescale = '0;
            next_r.tick     = 1'b1;
        end else begin
            next_r.prescale = CW'(r.prescale + 1'b1);
        end

        if (r.tick) begin
            next_r.cal = advance(r.cal);
        end

        if (i_req.rd) begin
            next_r.rdata = read_mux(r, i_req.addr);
        end

        if (i_req.wr) begin
            // Any write other than to the unlock location spends the unlock
            next_r.unlock = (i_req.addr == rcr_pkg::ADDR_UNLOCK);
            if (i_req.addr == rcr_pkg::ADDR_TRIM) begin
                next_r.trim = i_req.wdata[6:0];
            end
            // A firmware write beats a carry landing on the same field
            if (r.unlock) begin
                case (i_req.addr)
                    rcr_pkg::ADDR_SEC:   next_r.cal.seconds_count   = i_req.wdata[5:0];
                    rcr_pkg::ADDR_MIN:   next_r.cal.minutes_count   = i_req.wdata[5:0];
                    rcr_pkg::ADDR_HOUR:  next_r.cal.hours_count     = i_req.wdata[4:0];
                    rcr_pkg::ADDR_WDAY:  next_r.cal.weekday_count   = i_req.wdata[2:0];
                    rcr_pkg::ADDR_MDAY:  next_r.cal.month_day_count = i_req.wdata[4:0];
                    rcr_pkg::ADDR_MONTH: next_r.cal.month_count     = i_req.wdata[3:0];
                    rcr_pkg::ADDR_YEAR:  next_r.cal.year_count      = i_req.wdata;
                    default: ;
                endcase
            end
        end

        // Calendar is deliberately left out of reset so time survives it
        if (!i_rst_n) begin
            next_r.trim     = rcr_pkg::TRIM_RESET;
            next_r.unlock   = 1'b0;
            next_r.prescale = '0;
            next_r.tick     = 1'b0;
            next_r.rdata    = '0;
        end
    end

    // Calendar flops are never cleared; contents hold for as long as the supply does
    always_ff @(posedge i_mclk) begin
        r <= next_r;
    end

    assign o_rdata            = r.rdata;
    assign o_analog_rate_trim = r.trim;
    assign o_calendar         = r.cal;
    assign o_second_tick      = r.tick;

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);

    logic leap_feb_end;
    logic day_end;
    assign day_end = r.tick && r.cal.seconds_count == rcr_pkg::SEC_MAX
                     && r.cal.minutes_count == rcr_pkg::MIN_MAX && r.cal.hours_count == rcr_pkg::HOUR_MAX;
    assign leap_feb_end = day_end && r.cal.month_count == rcr_pkg::MONTH_FEB
                          && r.cal.month_day_count == 5'h1c && is_leap(r.cal.year_count);

    trim_reset_a: assert property (disable iff (1'b0) !i_rst_n |=> r.trim == 7'h40)
        else $error("trim register not at reset value");

    unlocked_write_a: assert property (r.unlock && i_req.wr && i_req.addr == rcr_pkg::ADDR_MIN
        |=> r.cal.minutes_count == $past(i_req.wdata[5:0]))
        else $error("unlocked minute write not stored");

    locked_write_a: assert property (!r.unlock && i_req.wr && i_req.addr == rcr_pkg::ADDR_WDAY && !r.tick
        |=> r.cal.weekday_count == $past(r.cal.weekday_count))
        else $error("locked weekday write took effect");

    unlock_spent_a: assert property (i_req.wr && i_req.addr != rcr_pkg::ADDR_UNLOCK |=> !r.unlock)
        else $error("unlock survived another write");

    minute_wrap_a: assert property (r.tick && r.cal.seconds_count == rcr_pkg::SEC_MAX && !i_req.wr
        |=> r.cal.seconds_count == 6'h00 && r.cal.minutes_count != $past(r.cal.minutes_count))
        else $error("seconds did not wrap into minutes");

    hour_wrap_a: assert property (day_end && !i_req.wr |=> r.cal.hours_count == 5'h00)
        else $error("hours did not wrap at midnight");

    weekday_wrap_a: assert property (day_end && r.cal.weekday_count == 3'h7 && !i_req.wr
        |=> r.cal.weekday_count == 3'h1)
        else $error("weekday did not wrap to first day");

    leap_day_a: assert property (leap_feb_end && !i_req.wr |=> r.cal.month_day_count == 5'h1d
        && r.cal.month_count == 4'h2)
        else $error("leap February lacks day 29");

    // Checked from the first reset edge only: before firmware sets the time the calendar is unknown
    reset_keeps_a: assert property (disable iff (1'b0) !i_rst_n && $past(i_rst_n) && !r.tick && !i_req.wr
        |=> r.cal == $past(r.cal))
        else $error("reset disturbed calendar");

    tick_spacing_a: assert property (r.tick |=> !r.tick [*1])
        else $error("second tick longer than one cycle");

    read_return_a: assert property (i_req.rd && i_req.addr == rcr_pkg::ADDR_TRIM && !i_req.wr
        |=> o_rdata == {1'b0, $past(r.trim)} ##1 o_rdata == 8'h00 || $past(i_req.rd))
        else $error("read data not returned in following cycle");

    trim_write_a: assert property (i_req.wr && i_req.addr == rcr_pkg::ADDR_TRIM
        |=> r.trim == $past(i_req.wdata[6:0]))
        else $error("trim write not stored");

    trim_hold_a: assert property (!(i_req.wr && i_req.addr == rcr_pkg::ADDR_TRIM)
        |=> r.trim == $past(r.trim))
        else $error("trim changed without a write");

    unlock_set_a: assert property (i_req.wr && i_req.addr == rcr_pkg::ADDR_UNLOCK
        |=> r.unlock)
        else $error("unlock write did not arm");

    unlock_keep_a: assert property (!i_req.wr
        |=> r.unlock == $past(r.unlock))
        else $error("unlock changed without a write");

    locked_minute_a: assert property (!r.unlock && i_req.wr && i_req.addr == rcr_pkg::ADDR_MIN && !r.tick
        |=> r.cal.minutes_count == $past(r.cal.minutes_count))
        else $error("locked minute write took effect");

    unlocked_hour_a: assert property (r.unlock && i_req.wr && i_req.addr == rcr_pkg::ADDR_HOUR
        |=> r.cal.hours_count == $past(i_req.wdata[4:0]))
        else $error("unlocked hour write not stored");

    unlocked_year_a: assert property (r.unlock && i_req.wr && i_req.addr == rcr_pkg::ADDR_YEAR
        |=> r.cal.year_count == $past(i_req.wdata))
        else $error("unlocked year write not stored");

    second_step_a: assert property (r.tick && r.cal.seconds_count < rcr_pkg::SEC_MAX && !i_req.wr
        |=> r.cal.seconds_count == $past(r.cal.seconds_count) + 6'h01)
        else $error("seconds did not step by one");

    tick_period_a: assert property (r.prescale == CW'(SEC_CYCLES - 1)
        |=> r.tick && r.prescale == '0)
        else $error("second tick not at prescaler wrap");

    month_end_a: assert property (day_end && !i_req.wr && r.cal.month_count == 4'h4
        && r.cal.month_day_count == 5'h1e
        |=> r.cal.month_day_count == rcr_pkg::MDAY_FIRST && r.cal.month_count == 4'h5)
        else $error("thirty-day month did not roll over");

    common_feb_a: assert property (day_end && !i_req.wr && r.cal.month_count == rcr_pkg::MONTH_FEB
        && r.cal.month_day_count == 5'h1c && !is_leap(r.cal.year_count)
        |=> r.cal.month_day_count == rcr_pkg::MDAY_FIRST && r.cal.month_count == 4'h3)
        else $error("common February did not end on day 28");

    leap_end_a: assert property (day_end && !i_req.wr && r.cal.month_count == rcr_pkg::MONTH_FEB
        && r.cal.month_day_count == 5'h1d
        |=> r.cal.month_day_count == rcr_pkg::MDAY_FIRST && r.cal.month_count == 4'h3)
        else $error("February day 29 did not roll into March");

    year_wrap_a: assert property (day_end && !i_req.wr && r.cal.month_count == rcr_pkg::MONTH_LAST
        && r.cal.month_day_count == 5'h1f && r.cal.year_count == rcr_pkg::YEAR_MAX
        |=> r.cal.year_count == 8'h00 && r.cal.month_count == rcr_pkg::MONTH_FIRST)
        else $error("year did not wrap after 99");

    weekday_step_a: assert property (day_end && !i_req.wr && r.cal.weekday_count != 3'h0
        && r.cal.weekday_count < rcr_pkg::WDAY_LAST
        |=> r.cal.weekday_count == $past(r.cal.weekday_count) + 3'h1)
        else $error("weekday did not step by one");

    read_idle_a: assert property (!i_req.rd |=> o_rdata == 8'h00)
        else $error("read data present without a read");

    read_unlock_a: assert property (i_req.rd && i_req.addr == rcr_pkg::ADDR_UNLOCK
        |=> o_rdata == {7'h00, $past(r.unlock)})
        else $error("unlock flag read wrong");

    read_minute_a: assert property (i_req.rd && i_req.addr == rcr_pkg::ADDR_MIN
        |=> o_rdata == {2'h0, $past(r.cal.minutes_count)})
        else $error("minute read wrong");

    tick_seen_c: cover property (r.tick);
    unlocked_write_c: cover property (r.unlock && i_req.wr && i_req.addr == rcr_pkg::ADDR_SEC);
    leap_day_c: cover property (leap_feb_end);
    year_wrap_c: cover property (day_end && r.cal.month_count == 4'hc && r.cal.year_count == 8'h63);

endmodule

//--- pkg/rcr_pkg.sv
// Package for the calendar register block: offsets, field widths, reset values,
// timing counts and the structs that carry the register port and calendar state.
// Assumes one 50 MHz clock and a byte-wide register port with 16-bit addresses.
package rcr_pkg;

    // Register offsets
    localparam logic [15:0] ADDR_TRIM    = 16'h2011;
    localparam logic [15:0] ADDR_SEC     = 16'h2015;
    localparam logic [15:0] ADDR_MIN     = 16'h2016;
    localparam logic [15:0] ADDR_HOUR    = 16'h2017;
    localparam logic [15:0] ADDR_WDAY    = 16'h2018;
    localparam logic [15:0] ADDR_MDAY    = 16'h2019;
    localparam logic [15:0] ADDR_MONTH   = 16'h201a;
    localparam logic [15:0] ADDR_YEAR    = 16'h201b;
    localparam logic [15:0] ADDR_UNLOCK  = 16'h201f;

    // Field widths
    localparam int unsigned TRIM_W  = 7;
    localparam int unsigned SEC_W   = 6;
    localparam int unsigned MIN_W   = 6;
    localparam int unsigned HOUR_W  = 5;
    localparam int unsigned WDAY_W  = 3;
    localparam int unsigned MDAY_W  = 5;
    localparam int unsigned MONTH_W = 4;
    localparam int unsigned YEAR_W  = 8;

    // Reset value and field limits
    localparam logic [6:0] TRIM_RESET = 7'h40;
    localparam logic [5:0] SEC_MAX    = 6'h3b;
    localparam logic [5:0] MIN_MAX    = 6'h3b;
    localparam logic [4:0] HOUR_MAX   = 5'h17;
    localparam logic [2:0] WDAY_FIRST = 3'h1;
    localparam logic [2:0] WDAY_LAST  = 3'h7;
    localparam logic [4:0] MDAY_FIRST = 5'h01;
    localparam logic [3:0] MONTH_FEB  = 4'h2;
    localparam logic [3:0] MONTH_LAST = 4'hc;
    localparam logic [3:0] MONTH_FIRST = 4'h1;
    localparam logic [7:0] YEAR_MAX   = 8'h63;

    // Timing
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned SECOND_NS     = 1000000000;
    localparam int unsigned SEC_CYCLES    = SECOND_NS / CLK_PERIOD_NS;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } rcr_bus_req_t;

    typedef struct packed {
        logic [SEC_W-1:0]   seconds_count;
        logic [MIN_W-1:0]   minutes_count;
        logic [HOUR_W-1:0]  hours_count;
        logic [WDAY_W-1:0]  weekday_count;
        logic [MDAY_W-1:0]  month_day_count;
        logic [MONTH_W-1:0] month_count;
        logic [YEAR_W-1:0]  year_count;
    } rcr_cal_t;

endpackage

//--- tb/testbench.sv
// Self-checking bench for the calendar register block: bus tasks, rollover table,
// unlock handling and reset retention.
// Assumes rcr_pkg is compiled first; the second length is shortened to 40 clocks.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin n_fail++; \
    $display("wrong value %s expected %h seen %h", nm, exp, got); end end

module testbench;
    localparam int unsigned SEC_N = 40;
    logic                  i_mclk = 1'b0;
    logic                  i_rst_n = 1'b0;
    rcr_pkg::rcr_bus_req_t i_req = '0;
    logic [7:0]            o_rdata;
    logic [6:0]            o_analog_rate_trim;
    rcr_pkg::rcr_cal_t     o_calendar;
    logic                  o_second_tick;
    int                    n_fail = 0;
    int                    samples_checked = 0;
    int                    gap;
    logic [7:0]            rd_val;
    rcr_pkg::rcr_cal_t     saved;
    rcr_pkg::rcr_cal_t     starts [6];
    rcr_pkg::rcr_cal_t     ends [6];

    always #10 i_mclk = ~i_mclk;

    rcr_calendar #(.SEC_CYCLES(SEC_N)) DUT (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_req(i_req),
        .o_rdata(o_rdata), .o_analog_rate_trim(o_analog_rate_trim), .o_calendar(o_calendar),
        .o_second_tick(o_second_tick));

    function automatic rcr_pkg::rcr_cal_t mk(int s, int m, int h, int w, int d, int mo, int y);
        mk = {6'(s), 6'(m), 5'(h), 3'(w), 5'(d), 4'(mo), 8'(y)};
    endfunction

    // Field i sits at offset ADDR_SEC + i, zero-extended to a byte
    function automatic logic [7:0] fld(rcr_pkg::rcr_cal_t c, int i);
        case (i)
            0: fld = {2'h0, c.seconds_count};
            1: fld = {2'h0, c.minutes_count};
            2: fld = {3'h0, c.hours_count};
            3: fld = {5'h0, c.weekday_count};
            4: fld = {3'h0, c.month_day_count};
            5: fld = {4'h0, c.month_count};
            default: fld = c.year_count;
        endcase
    endfunction

    task automatic wr(logic [15:0] a, logic [7:0] d);
        @(posedge i_mclk);
        i_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_mclk);
        i_req.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(logic [15:0] a, output logic [7:0] d);
        @(posedge i_mclk);
        i_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge i_mclk);
        i_req.rd <= 1'b0;
        #1;
        d = o_rdata;
    endtask

    task automatic wait_tick(output int c);
        c = 0;
        do begin
            @(posedge i_mclk);
            #1;
            c++;
        end while (o_second_tick !== 1'b1 && c < 100);
        if (c >= 100) begin
            n_fail++;
            $display("wrong value second_tick expected 1 seen 0");
        end
    endtask

    // Seconds go last so no carry can disturb the fields already set
    task automatic set_cal(rcr_pkg::rcr_cal_t c);
        for (int i = 6; i >= 0; i--) begin
            wr(rcr_pkg::ADDR_UNLOCK, 8'h00);
            wr(rcr_pkg::ADDR_SEC + 16'(i), fld(c, i));
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        #200000;
        n_fail++;
        finish_test();
    end

    initial begin
        starts[0] = mk(59, 59, 23, 7, 28, 2, 4);
        ends[0]   = mk(0, 0, 0, 1, 29, 2, 4);
        starts[1] = mk(59, 59, 23, 3, 28, 2, 5);
        ends[1]   = mk(0, 0, 0, 4, 1, 3, 5);
        starts[2] = mk(59, 59, 23, 2, 29, 2, 0);
        ends[2]   = mk(0, 0, 0, 3, 1, 3, 0);
        starts[3] = mk(59, 59, 23, 5, 31, 12, 99);
        ends[3]   = mk(0, 0, 0, 6, 1, 1, 0);
        starts[4] = mk(59, 59, 23, 1, 30, 4, 10);
        ends[4]   = mk(0, 0, 0, 2, 1, 5, 10);
        starts[5] = mk(59, 58, 10, 2, 15, 6, 20);
        ends[5]   = mk(0, 59, 10, 2, 15, 6, 20);
        repeat (5) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        rd(rcr_pkg::ADDR_TRIM, rd_val);
        `CHK("trim reset", 8'h40, rd_val)
        wr(rcr_pkg::ADDR_TRIM, 8'hff);
        rd(rcr_pkg::ADDR_TRIM, rd_val);
        `CHK("trim width", 8'h7f, rd_val)
        rd(16'h2012, rd_val);
        `CHK("unmapped read", 8'h00, rd_val)
        wait_tick(gap);
        wait_tick(gap);
        `CHK("tick spacing", SEC_N, gap)
        for (int k = 0; k < 6; k++) begin
            wait_tick(gap);
            set_cal(starts[k]);
            wait_tick(gap);
            @(posedge i_mclk);
            #1;
            `CHK("calendar", ends[k], o_calendar)
            for (int i = 0; i < 7; i++) begin
                rd(rcr_pkg::ADDR_SEC + 16'(i), rd_val);
                `CHK("field read", fld(ends[k], i), rd_val)
            end
        end
        // Minutes cannot carry here: seconds restarted from 0 a few clocks ago
        wr(rcr_pkg::ADDR_MIN, 8'h11);
        rd(rcr_pkg::ADDR_MIN, rd_val);
        `CHK("locked write", 8'h3b, rd_val)
        wr(rcr_pkg::ADDR_WDAY, 8'h05);
        rd(rcr_pkg::ADDR_WDAY, rd_val);
        `CHK("locked weekday", 8'h02, rd_val)
        wr(rcr_pkg::ADDR_UNLOCK, 8'h00);
        wr(rcr_pkg::ADDR_TRIM, 8'h15);
        wr(rcr_pkg::ADDR_MIN, 8'h22);
        rd(rcr_pkg::ADDR_MIN, rd_val);
        `CHK("spent unlock", 8'h3b, rd_val)
        wr(rcr_pkg::ADDR_UNLOCK, 8'h00);
        rd(rcr_pkg::ADDR_UNLOCK, rd_val);
        `CHK("unlock flag", 8'h01, rd_val)
        wr(rcr_pkg::ADDR_MIN, 8'h2a);
        rd(rcr_pkg::ADDR_MIN, rd_val);
        `CHK("unlocked write", 8'h2a, rd_val)
        `CHK("trim out", 7'h15, o_analog_rate_trim)
        wait_tick(gap);
        @(posedge i_mclk);
        #1;
        saved = o_calendar;
        @(posedge i_mclk);
        i_rst_n <= 1'b0;
        repeat (3) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        @(posedge i_mclk);
        #1;
        `CHK("calendar over reset", saved, o_calendar)
        `CHK("trim after reset", 7'h40, o_analog_rate_trim)
        finish_test();
    end
endmodule
